// ==== common/brs_map.svh ====
// Register offsets, field positions, reset values and timing counts of the brown-out sequencer
`ifndef BRS_MAP_SVH
`define BRS_MAP_SVH
`define BRS_CTRL_OFF 12'h000
`define BRS_STATUS_OFF 12'h004
`define BRS_RESET_CONTROL_REG_OFF 12'h008
`define BRS_CTRL_OSEL_LSB 0
`define BRS_CTRL_PMODE_LSB 4
`define BRS_CTRL_POWER_UP_TIMER_EN_BIT 8
`define BRS_CTRL_RESET 32'h0000_0000
`define BRS_CTRL_WMASK 32'h0000_0137
`define BRS_STAT_HOLD_BIT 0
`define BRS_STAT_IRST_BIT 1
`define BRS_STAT_OST_BIT 2
`define BRS_STAT_POWER_UP_TIMER_BIT 3
`define BRS_RESET_CONTROL_REG_BOR_BIT 1
`define BRS_OSC_LOCK_BIT 5
`define BRS_CLK_NS 5
`define BRS_RST_PULSE_NS 50
`define BRS_RST_PULSE_CYC ((`BRS_RST_PULSE_NS + `BRS_CLK_NS - 1) / `BRS_CLK_NS)
`define BRS_OST_CYCLES 1024
`define BRS_POWER_UP_TIMER_CYCLES 8192
`define BRS_FSCM_CYCLES 6000
`endif

// ==== common/brs_pkg.sv ====
// Types shared by the brown-out reset sequencer
package brs_pkg;
    typedef enum logic [2:0] {
        BRS_OSC_FRC = 3'h0,
        BRS_OSC_FRCPLL = 3'h1,
        BRS_OSC_PRI = 3'h2,
        BRS_OSC_PRIPLL = 3'h3,
        BRS_OSC_RSVD = 3'h4,
        BRS_OSC_LPRC = 3'h5,
        BRS_OSC_FRC16 = 3'h6,
        BRS_OSC_FRCDIVN = 3'h7
    } brs_osc_sel_t;
    typedef enum logic [1:0] {
        BRS_PM_EXT = 2'h0,
        BRS_PM_XT = 2'h1,
        BRS_PM_HS = 2'h2,
        BRS_PM_OFF = 2'h3
    } brs_pmode_t;
    typedef struct packed {
        brs_osc_sel_t osc_select_cfg;
        brs_pmode_t primary_osc_mode_cfg;
        logic power_up_timer_en;
    } brs_cfg_t;
    typedef struct packed {
        logic use_osc;
        logic use_pll;
        logic crystal;
        logic [2:0] clk_src;
    } brs_clk_plan_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } brs_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } brs_apb_rsp_t;
endpackage

// ==== hdl/brs_timer.sv ====
// Loadable down-counter signalling expiry, stepped by an enable
`timescale 1ns/1ps
`default_nettype none
module brs_timer #(
    parameter int WIDTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    input wire logic step,
    output logic done
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic done;
    } brs_tmr_state_t;
    brs_tmr_state_t st_reg;
    brs_tmr_state_t st_next;
    // Narrower counters cannot tell a load of one from expiry
    if (WIDTH < 2) begin : g_bad_width
        $error("brs_timer: WIDTH too small");
    end
    always_comb begin
        st_next = st_reg;
        if (load) begin
            st_next.cnt = count;
            st_next.done = (count == '0);
        end else if (step && !st_reg.done) begin
            st_next.cnt = st_reg.cnt - 1'b1;
            st_next.done = (st_reg.cnt == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign done = st_reg.done;
endmodule
`default_nettype wire

// ==== hdl/brs_apb_regs.sv ====
// APB slave holding the sequencer configuration and reset control words and reading back the status word
`timescale 1ns/1ps
`default_nettype none
`include "brs_map.svh"
module brs_apb_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire brs_pkg::brs_apb_req_t apb_req,
    output brs_pkg::brs_apb_rsp_t apb_rsp,
    input wire logic [31:0] status_word,
    input wire logic bor_set,
    output brs_pkg::brs_cfg_t cfg,
    output logic bor_flag
);
    import brs_pkg::*;
    typedef struct packed {
        logic [31:0] ctrl;
        logic bor;
        brs_apb_rsp_t rsp;
    } brs_reg_state_t;
    brs_reg_state_t st_reg;
    brs_reg_state_t st_next;
    logic wr;
    logic rd;
    always_comb begin
        st_next = st_reg;
        wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
        rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
        st_next.rsp.pready = apb_req.psel && !apb_req.penable;
        st_next.rsp.pslverr = 1'b0;
        if (apb_req.psel && !apb_req.penable) begin
            st_next.rsp.prdata = 32'h0000_0000;
            case (apb_req.paddr)
                `BRS_CTRL_OFF: st_next.rsp.prdata = st_reg.ctrl;
                `BRS_STATUS_OFF: st_next.rsp.prdata = status_word;
                `BRS_RESET_CONTROL_REG_OFF: st_next.rsp.prdata[`BRS_RESET_CONTROL_REG_BOR_BIT] = st_reg.bor;
                default: st_next.rsp.pslverr = 1'b1;
            endcase
        end
        // Write one clears; a simultaneous brown-out wins
        if (wr && apb_req.paddr == `BRS_CTRL_OFF) begin
            st_next.ctrl = apb_req.pwdata & `BRS_CTRL_WMASK;
        end
        if (wr && apb_req.paddr == `BRS_RESET_CONTROL_REG_OFF && apb_req.pwdata[`BRS_RESET_CONTROL_REG_BOR_BIT]) begin
            st_next.bor = 1'b0;
        end
        if (bor_set) begin
            st_next.bor = 1'b1;
        end
        if (rd) begin
            st_next.rsp.pready = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign apb_rsp = st_reg.rsp;
    assign cfg.osc_select_cfg = brs_osc_sel_t'(st_reg.ctrl[`BRS_CTRL_OSEL_LSB +: 3]);
    assign cfg.primary_osc_mode_cfg = brs_pmode_t'(st_reg.ctrl[`BRS_CTRL_PMODE_LSB +: 2]);
    assign cfg.power_up_timer_en = st_reg.ctrl[`BRS_CTRL_POWER_UP_TIMER_EN_BIT];
    assign bor_flag = st_reg.bor;
endmodule
`default_nettype wire

// ==== hdl/brs_sequencer.sv ====
// Brown-out reset sequencer: reset pulse, clock hold and power-up delay
`timescale 1ns/1ps
`default_nettype none
`include "brs_map.svh"
module brs_sequencer #(
    parameter int OST_CYCLES = `BRS_OST_CYCLES,
    parameter int POWER_UP_TIMER_CYCLES = `BRS_POWER_UP_TIMER_CYCLES,
    parameter int FSCM_CYCLES = `BRS_FSCM_CYCLES,
    parameter int TW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire brs_pkg::brs_apb_req_t apb_req,
    output brs_pkg::brs_apb_rsp_t apb_rsp,
    input wire logic brownout_detect,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic pll_lock,
    input wire logic osc_tick,
    output logic device_reset,
    output logic internal_reset,
    output logic sysclk_hold,
    output logic [2:0] clk_src_sel,
    output logic pll_enable,
    output logic instr_cycle_en,
    output logic brownout_reset_flag
);
    import brs_pkg::*;
    localparam int PULSE_CYC = `BRS_RST_PULSE_CYC;

    // Refused at elaboration: the timers cannot hold wider counts
    if (TW < 2 || TW > 31) begin : g_bad_tw
        $error("TW must lie between 2 and 31");
    end
    if (OST_CYCLES < 1 || OST_CYCLES >= (1 << TW)) begin : g_bad_ost
        $error("OST_CYCLES out of range");
    end
    if (POWER_UP_TIMER_CYCLES < 0 || POWER_UP_TIMER_CYCLES >= (1 << TW)) begin : g_bad_power_up_timer
        $error("POWER_UP_TIMER_CYCLES out of range");
    end
    if (FSCM_CYCLES < 1 || FSCM_CYCLES >= (1 << TW)) begin : g_bad_fscm
        $error("FSCM_CYCLES out of range");
    end
    if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
        $error("Reset pulse does not fit its counter");
    end

    // Oscillator selection and primary mode decode into a clock plan
    function automatic brs_clk_plan_t plan_clock(input brs_cfg_t c);
        brs_clk_plan_t p;
        p = '0;
        p.clk_src = c.osc_select_cfg;
        case (c.osc_select_cfg)
            BRS_OSC_FRC: begin
                p.use_pll = 1'b0;
            end
            BRS_OSC_FRCPLL: begin
                p.use_pll = 1'b1;
            end
            BRS_OSC_PRI: begin
                p.use_osc = (c.primary_osc_mode_cfg != BRS_PM_OFF);
            end
            BRS_OSC_PRIPLL: begin
                p.use_osc = (c.primary_osc_mode_cfg != BRS_PM_OFF);
                p.use_pll = 1'b1;
            end
            BRS_OSC_RSVD: begin
                // Reserved code falls back to the fast RC source
                p.clk_src = BRS_OSC_FRC;
            end
            BRS_OSC_LPRC, BRS_OSC_FRC16, BRS_OSC_FRCDIVN: begin
                p.use_pll = 1'b0;
            end
            default: begin
                p.clk_src = BRS_OSC_FRC;
            end
        endcase
        p.crystal = p.use_osc && (c.primary_osc_mode_cfg == BRS_PM_XT ||
            c.primary_osc_mode_cfg == BRS_PM_HS);
        return p;
    endfunction

    // Power-up delay length; zero delay on a crystal still waits out the monitor
    function automatic logic [TW-1:0] pick_delay(input logic power_up_timer_en, input logic crystal);
        logic [TW-1:0] d;
        d = '0;
        if (power_up_timer_en) begin
            d = TW'(POWER_UP_TIMER_CYCLES);
        end else if (crystal) begin
            d = TW'(FSCM_CYCLES);
        end
        return d;
    endfunction

    // Software view of the sequence progress
    function automatic logic [31:0] pack_status(input logic hold, input logic irst,
        input logic osc_startup_timer, input logic power_up_timer, input logic lock);
        logic [31:0] w;
        w = '0;
        w[`BRS_STAT_HOLD_BIT] = hold;
        w[`BRS_STAT_IRST_BIT] = irst;
        w[`BRS_STAT_OST_BIT] = osc_startup_timer;
        w[`BRS_STAT_POWER_UP_TIMER_BIT] = power_up_timer;
        w[`BRS_OSC_LOCK_BIT] = lock;
        return w;
    endfunction

    // Returns next phase and enable; the enable fires on every second running tick
    function automatic logic [1:0] cycle_step(input logic tick, input logic held,
        input logic phase);
        logic [1:0] r;
        r = {phase, 1'b0};
        if (tick && !held) begin
            r[1] = !phase;
            r[0] = phase;
        end
        return r;
    endfunction

    // System clock may run once its source and PLL are settled
    function automatic logic clock_is_ready(input brs_clk_plan_t p, input logic osc_startup_timer,
        input logic lock);
        logic ok;
        ok = 1'b1;
        if (p.use_osc && !osc_startup_timer) begin
            ok = 1'b0;
        end
        if (p.use_pll && !lock) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    typedef enum logic [4:0] {
        S_RUN = 5'b00001,
        S_PULSE = 5'b00010,
        S_LOAD = 5'b00100,
        S_WAIT = 5'b01000,
        S_DONE = 5'b10000
    } brs_state_t;

    typedef struct packed {
        brs_state_t fsm;
        logic [7:0] pulse_cnt;
        brs_clk_plan_t plan;
        logic dev_rst;
        logic int_rst;
        logic hold;
        logic bor_set;
        logic cyc_phase;
        logic cyc_en;
    } brs_seq_state_t;

    // Idle after power-on: no sequence running, every output low
    localparam brs_seq_state_t SEQ_IDLE = '{
        fsm: S_RUN,
        pulse_cnt: 8'h00,
        plan: '0,
        dev_rst: 1'b0,
        int_rst: 1'b0,
        hold: 1'b0,
        bor_set: 1'b0,
        cyc_phase: 1'b0,
        cyc_en: 1'b0
    };

    // A new brown-out restarts the whole sequence from the reset pulse
    function automatic brs_seq_state_t restart(input brs_seq_state_t s);
        brs_seq_state_t r;
        r = s;
        r.fsm = S_PULSE;
        r.pulse_cnt = 8'(PULSE_CYC);
        r.dev_rst = 1'b1;
        r.int_rst = 1'b1;
        r.hold = 1'b1;
        r.cyc_phase = 1'b0;
        return r;
    endfunction

    brs_seq_state_t st_reg;
    brs_seq_state_t st_next;
    brs_cfg_t cfg;
    logic bor_flag;
    logic ost_done;
    logic power_up_timer_done;
    logic [TW-1:0] delay_count;
    logic [31:0] status_word;
    logic tmr_load;
    logic clock_ready;
    brs_clk_plan_t new_plan;

    brs_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .status_word(status_word),
        .bor_set(st_reg.bor_set),
        .cfg(cfg),
        .bor_flag(bor_flag)
    );

    brs_timer #(.WIDTH(TW)) u_ost (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .count(TW'(OST_CYCLES)),
        .step(osc_tick),
        .done(ost_done)
    );

    // Power-up delay counts on the free-running reference clock
    brs_timer #(.WIDTH(TW)) u_power_up_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .count(delay_count),
        .step(1'b1),
        .done(power_up_timer_done)
    );

    always_comb begin
        new_plan = plan_clock(cfg);
        tmr_load = (st_reg.fsm == S_LOAD);
        // Taken from the plan latched now; the stored one belongs to the last sequence
        delay_count = pick_delay(cfg.power_up_timer_en, new_plan.crystal);
        clock_ready = clock_is_ready(st_reg.plan, ost_done, pll_lock);
        status_word = pack_status(st_reg.hold, st_reg.int_rst, ost_done, power_up_timer_done, pll_lock);
    end

    always_comb begin
        st_next = st_reg;
        st_next.bor_set = 1'b0;
        // Instruction cycle enable every second oscillator tick while the system clock is not held
        {st_next.cyc_phase, st_next.cyc_en} =
            cycle_step(osc_tick, st_reg.hold, st_reg.cyc_phase);
        case (st_reg.fsm)
            S_RUN: begin
                st_next.fsm = S_RUN;
            end
            S_DONE: begin
                // Flag set is under way; settle back to watching
                st_next.fsm = S_RUN;
            end
            S_PULSE: begin
                if (st_reg.pulse_cnt == 8'h01) begin
                    st_next.dev_rst = 1'b0;
                    st_next.fsm = S_LOAD;
                end else begin
                    st_next.pulse_cnt = st_reg.pulse_cnt - 8'h01;
                end
            end
            S_LOAD: begin
                st_next.plan = new_plan;
                st_next.fsm = S_WAIT;
            end
            S_WAIT: begin
                // Clock may run before the delay ends; reset waits for both
                if (clock_ready) begin
                    st_next.hold = 1'b0;
                end
                if (clock_ready && power_up_timer_done) begin
                    st_next.int_rst = 1'b0;
                    st_next.bor_set = 1'b1;
                    st_next.fsm = S_DONE;
                end
            end
            default: st_next.fsm = S_RUN;
        endcase
        // Sleep and Idle do not gate detection; a new brown-out restarts
        if (brownout_detect || ((sleep_mode || idle_mode) && brownout_detect)) begin
            st_next = restart(st_next);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= SEQ_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign device_reset = st_reg.dev_rst;
    assign internal_reset = st_reg.int_rst;
    assign sysclk_hold = st_reg.hold;
    assign clk_src_sel = st_reg.plan.clk_src;
    assign pll_enable = st_reg.plan.use_pll;
    assign instr_cycle_en = st_reg.cyc_en;
    assign brownout_reset_flag = bor_flag;
endmodule
`default_nettype wire

// ==== tb/brs_seq_assertions.sv ====
// Port-level checks of the brown-out reset sequencer
`timescale 1ns/1ps
`default_nettype none
module brs_seq_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire brs_pkg::brs_apb_req_t apb_req,
    input wire brs_pkg::brs_apb_rsp_t apb_rsp,
    input wire logic brownout_detect,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic pll_lock,
    input wire logic osc_tick,
    input wire logic device_reset,
    input wire logic internal_reset,
    input wire logic sysclk_hold,
    input wire logic [2:0] clk_src_sel,
    input wire logic pll_enable,
    input wire logic instr_cycle_en,
    input wire logic brownout_reset_flag
);
    import brs_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    det_reset_a: assert property (
        brownout_detect |=> device_reset && internal_reset && sysclk_hold)
        else $error("Reset not raised on brown-out");
    low_power_a: assert property (
        brownout_detect && (sleep_mode || idle_mode) |=> device_reset)
        else $error("Brown-out ignored in low-power mode");
    pulse_len_a: assert property (
        $fell(device_reset) |-> $past(device_reset, 10))
        else $error("Reset pulse too short");
    hold_during_a: assert property (
        device_reset |-> internal_reset && sysclk_hold)
        else $error("Hold or reset dropped during pulse");
    release_order_a: assert property (
        $fell(internal_reset) |-> !sysclk_hold && !device_reset)
        else $error("Internal reset released while clock held");
    flag_set_a: assert property (
        $fell(internal_reset) |-> ##[0:1] brownout_reset_flag)
        else $error("Brown-out flag not set after release");
    pll_wait_a: assert property (
        $fell(sysclk_hold) && pll_enable |-> $past(pll_lock))
        else $error("Clock released before lock");
    src_code_a: assert property (
        clk_src_sel != 3'h4 && pll_enable == (clk_src_sel inside {3'h1, 3'h3}))
        else $error("Clock source or PLL use inconsistent");
    icyc_pulse_a: assert property (
        instr_cycle_en |=> !instr_cycle_en)
        else $error("Instruction cycle pulse too long");
    rel_c: cover property ($fell(internal_reset));
    pll_c: cover property ($fell(sysclk_hold) && pll_enable);
    err_c: cover property (apb_rsp.pslverr);
endmodule
bind brs_sequencer brs_seq_assertions brs_seq_assertions_i (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .brownout_detect(brownout_detect), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .pll_lock(pll_lock), .osc_tick(osc_tick), .device_reset(device_reset),
    .internal_reset(internal_reset), .sysclk_hold(sysclk_hold), .clk_src_sel(clk_src_sel),
    .pll_enable(pll_enable), .instr_cycle_en(instr_cycle_en),
    .brownout_reset_flag(brownout_reset_flag));
`default_nettype wire

// ==== tb/brs_sequencer_tb.sv ====
// Self-checking bench for the brown-out reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "brs_map.svh"
module brs_sequencer_tb;
    import brs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    brs_apb_req_t req = '0;
    brs_apb_rsp_t rsp;
    logic det = 1'b0, slp = 1'b0, idl = 1'b0, lock = 1'b0, tick = 1'b0;
    logic dev_rst, int_rst, hold, pll_en, icyc, flag, err;
    logic [2:0] src;
    logic [31:0] rd;
    int num_errors = 0;
    int n_compared = 0;
    // Every primary mode code and six of the eight oscillator codes; minimum release times with timers of 4, 20 and 12
    logic [31:0] cfgs [8] = '{32'h112, 32'h012, 32'h002, 32'h023, 32'h031, 32'h030, 32'h004, 32'h037};
    logic [2:0] srcs [8] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h1, 3'h0, 3'h0, 3'h7};
    int mins [8] = '{30, 22, 18, 61, 61, 10, 10, 10};
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) tick <= ~tick;
    brs_sequencer #(.OST_CYCLES(4), .POWER_UP_TIMER_CYCLES(20), .FSCM_CYCLES(12)) brs_sequencer_i (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .brownout_detect(det),
        .sleep_mode(slp), .idle_mode(idl), .pll_lock(lock), .osc_tick(tick),
        .device_reset(dev_rst), .internal_reset(int_rst), .sysclk_hold(hold),
        .clk_src_sel(src), .pll_enable(pll_en), .instr_cycle_en(icyc),
        .brownout_reset_flag(flag));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        if (k >= 20) chk("pready", 1, 0);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        int c;
        int n;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("idle_outs", 0, {dev_rst, int_rst, hold, flag});
        apb(0, `BRS_CTRL_OFF, 0);
        chk("ctrl_reset", `BRS_CTRL_RESET, rd);
        apb(1, `BRS_CTRL_OFF, 32'hffff_ffff);
        apb(0, `BRS_CTRL_OFF, 0);
        chk("ctrl_mask", 32'h0000_0137, rd);
        apb(0, 12'h00c, 0);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, rd);
        for (int i = 0; i < 8; i++) begin
            apb(1, `BRS_CTRL_OFF, cfgs[i]);
            apb(0, `BRS_CTRL_OFF, 0);
            chk("ctrl_rd", cfgs[i], rd);
            @(posedge pclk);
            lock <= 1'b0;
            slp <= i[0];
            idl <= i[1];
            det <= 1'b1;
            repeat (3) @(posedge pclk);
            chk("dev_rst", 1, dev_rst);
            det <= 1'b0;
            c = 0;
            // Lock withheld so a PLL plan must keep the clock held
            while (int_rst === 1'b1 && c < 2000) begin
                @(posedge pclk);
                c++;
                if (c == 60) begin
                    chk("hold_pll", srcs[i] == 3'h1 || srcs[i] == 3'h3, hold);
                    lock <= 1'b1;
                end
            end
            chk("delay_min", 1, c >= mins[i]);
            chk("delay_max", 1, c <= mins[i] + 6);
            chk("hold_off", 0, hold);
            chk("src", srcs[i], src);
            chk("pll_en", srcs[i] == 3'h1 || srcs[i] == 3'h3, pll_en);
            n = 0;
            repeat (40) begin
                @(posedge pclk);
                n += (icyc === 1'b1);
            end
            chk("icyc_cnt", 1, n >= 9 && n <= 11);
            apb(0, `BRS_STATUS_OFF, 0);
            chk("status", {26'h0, lock, 5'h0c}, rd);
            apb(0, `BRS_RESET_CONTROL_REG_OFF, 0);
            chk("bor_flag", 1, rd[`BRS_RESET_CONTROL_REG_BOR_BIT]);
            chk("flag_pin", 1, flag);
            apb(1, `BRS_RESET_CONTROL_REG_OFF, 32'h2);
            apb(0, `BRS_RESET_CONTROL_REG_OFF, 0);
            chk("bor_clr", 0, rd[`BRS_RESET_CONTROL_REG_BOR_BIT]);
            chk("flag_pin_clr", 0, flag);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
